// ---- logic/exposure_gain_feature_regs.sv ----
`include "feature_params.svh"
// Function
// - Exposure presence bit reads one, read-only
// - Exposure absolute-control bit reads zero, read-only
// - One-shot auto bit reads zero in both
// - Exposure on/off bit reads one, read-only
// - Exposure auto/manual bit reads zero (manual)
// - Exposure setting twelve bits, 1..4095, reset 200
// - Exposure duration is setting times 20 us
// - Gain presence bit reads one, read-only
// - Gain absolute-control bit reads zero, read-only
// - Gain on/off bit reads one, read-only
// - Gain auto/manual bit reads zero (manual)
// - Gain legal range 0..740 at 8-bit output
// - Gain legal range 0..125 at 16-bit output
// - Gain maps 0/125/740 to 0/8.2/20.2 dB
// - Gain default 150 at 8-bit, 0 at 16-bit
// - Out-of-range write flags error, setting still used
module exposure_gain_feature_regs (
	input wire logic clock,
	input wire logic srst,
	input wire feature_pkg::offset_t reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire feature_pkg::word_t reg_wdata,
	output feature_pkg::word_t reg_rdata_q,
	output logic reg_rvalid_q,
	input wire logic pix16_sel,
	input wire logic exposure_start,
	output feature_pkg::value_t exposure_value_q,
	output feature_pkg::value_t gain_value_q,
	output logic exposure_error_q,
	output logic gain_error_q,
	output logic exposing_q,
	output logic exposure_done_q,
	output feature_pkg::micros_t exposure_us_q,
	output feature_pkg::tenths_t gain_db_tenths_q
);
	import feature_pkg::*;

	// ==========================================================================
	// Helpers
	function automatic value_t gain_limit(input logic pix16);
		return pix16 ? `GAIN_MAX_16 : `GAIN_MAX_8;
	endfunction : gain_limit

	function automatic value_t gain_default(input logic pix16);
		return pix16 ? `GAIN_DEF_16 : `GAIN_DEF_8;
	endfunction : gain_default

	// Both feature words share one fixed capability pattern around the setting.
	function automatic word_t feature_word(input value_t v);
		word_t w;
		w = '0;
		w[`BIT_PRESENT] = 1'b1;
		w[`BIT_ABS] = 1'b0;
		w[`BIT_ONE_PUSH] = 1'b0;
		w[`BIT_ON_OFF] = 1'b1;
		w[`BIT_AUTO] = 1'b0;
		w[`VAL_MSB:`VAL_LSB] = v;
		return w;
	endfunction : feature_word

	// Exact match only: neither register answers at an alias of its offset.
	function automatic logic hits(input offset_t addr, input offset_t reg_off);
		return addr == reg_off;
	endfunction : hits

	// ==========================================================================
	// Decode
	logic wr_exp;
	logic wr_gain;
	logic depth_change;
	logic pix16_q;
	value_t wval;

	assign wr_exp = reg_wr && hits(reg_addr, `REG_EXPOSURE);
	assign wr_gain = reg_wr && hits(reg_addr, `REG_GAIN);
	assign wval = reg_wdata[`VAL_MSB:`VAL_LSB];
	assign depth_change = (pix16_sel != pix16_q);

	always_ff @(posedge clock) begin
		if (srst) begin
			pix16_q <= pix16_sel;
		end else begin
			pix16_q <= pix16_sel;
		end
	end

	// ==========================================================================
	// Exposure setting
	// An illegal value is stored and used anyway; only the flag tells software.
	always_ff @(posedge clock) begin
		if (srst) begin
			exposure_value_q <= `EXP_RESET;
		end else if (wr_exp) begin
			exposure_value_q <= wval;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			exposure_error_q <= 1'b0;
		end else if (wr_exp) begin
			exposure_error_q <= (wval < `EXP_MIN);
		end
	end

	// ==========================================================================
	// Gain setting
	// A change of pixel depth reloads the default for the new depth unless a gain write
	// in the same cycle wins; that write is flagged against the new limit, so the
	// stored value never silently falls outside the new legal range.
	always_ff @(posedge clock) begin
		if (srst) begin
			gain_value_q <= gain_default(pix16_sel);
		end else if (wr_gain) begin
			gain_value_q <= wval;
		end else if (depth_change) begin
			gain_value_q <= gain_default(pix16_sel);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			gain_error_q <= 1'b0;
		end else if (wr_gain) begin
			gain_error_q <= (wval > gain_limit(pix16_sel));
		end else if (depth_change) begin
			gain_error_q <= 1'b0;
		end
	end

	// ==========================================================================
	// Read port
	// A read in the same cycle as a write to that register returns the old value.
	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			reg_rdata_q <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`REG_EXPOSURE: reg_rdata_q <= feature_word(exposure_value_q);
				`REG_GAIN: reg_rdata_q <= feature_word(gain_value_q);
				default: reg_rdata_q <= '0;
			endcase
		end
	end

	// ==========================================================================
	// Applied exposure and gain
	exposure_timer u_exposure_timer (
		.clock(clock),
		.srst(srst),
		.start(exposure_start),
		.value(exposure_value_q),
		.exposing_q(exposing_q),
		.done_q(exposure_done_q),
		.duration_us_q(exposure_us_q)
	);

	gain_mapper u_gain_mapper (
		.clock(clock),
		.srst(srst),
		.value(gain_value_q),
		.db_tenths_q(gain_db_tenths_q)
	);

	// ==========================================================================
	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	logic rd_exp;
	logic rd_gain;
	logic rd_any;
	assign rd_exp = reg_rd && hits(reg_addr, `REG_EXPOSURE);
	assign rd_gain = reg_rd && hits(reg_addr, `REG_GAIN);
	assign rd_any = rd_exp || rd_gain;

	// Counts the cycles of the exposure in flight, so that its length can be
	// checked against the setting taken at start without a long repetition.
	logic [23:0] expose_len_q;
	value_t expose_set_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			expose_len_q <= '0;
			expose_set_q <= '0;
		end else if (exposure_start && !exposing_q) begin
			expose_len_q <= '0;
			expose_set_q <= exposure_value_q;
		end else if (exposing_q) begin
			expose_len_q <= expose_len_q + 24'h000001;
		end
	end

	AST_EXP_PRESENT: assert property (rd_exp |=> reg_rvalid_q && reg_rdata_q[`BIT_PRESENT])
		else $error("exposure presence bit not one");

	AST_EXP_ABS: assert property (rd_exp |=> !reg_rdata_q[`BIT_ABS])
		else $error("exposure absolute bit not zero");

	AST_ONE_PUSH: assert property (rd_any |=> !reg_rdata_q[`BIT_ONE_PUSH])
		else $error("one push bit not zero");

	AST_EXP_ON: assert property (rd_exp |=> reg_rdata_q[`BIT_ON_OFF])
		else $error("exposure on bit not one");

	AST_EXP_MANUAL: assert property (rd_exp |=> !reg_rdata_q[`BIT_AUTO])
		else $error("exposure not manual");

	AST_EXP_RESET: assert property ($past(srst) |-> exposure_value_q == `EXP_RESET)
		else $error("exposure reset value wrong");

	AST_EXP_READBACK: assert property (wr_exp ##1 rd_exp |=>
		reg_rdata_q[`VAL_MSB:`VAL_LSB] == $past(wval, 2))
		else $error("exposure readback mismatch");

	AST_EXP_WORD: assert property (rd_exp |=>
		reg_rdata_q[`VAL_MSB:`VAL_LSB] == $past(exposure_value_q))
		else $error("exposure word does not show the stored setting");

	AST_EXP_OK: assert property ((wr_exp && wval != '0) |=> !exposure_error_q)
		else $error("legal exposure flagged");

	AST_EXP_US: assert property ((exposure_start && !exposing_q) |=>
		exposure_us_q == micros_t'($past(exposure_value_q)) * micros_t'(`STEP_US))
		else $error("exposure duration wrong");

	AST_EXP_START_IGNORED: assert property ((exposing_q && exposure_start) |=>
		$stable(exposure_us_q))
		else $error("start during an exposure was taken");

	AST_EXP_LENGTH: assert property (exposure_done_q |->
		expose_len_q == 24'(expose_set_q) * 24'(`STEP_CYCLES))
		else $error("exposure length not setting times step");

	// ==========================================================================
	// Gain word, range, curve and default checks
	AST_GAIN_PRESENT: assert property (rd_gain |=> reg_rdata_q[`BIT_PRESENT])
		else $error("gain presence bit not one");

	AST_GAIN_ABS: assert property (rd_gain |=> !reg_rdata_q[`BIT_ABS])
		else $error("gain absolute bit not zero");

	AST_GAIN_ON: assert property (rd_gain |=> reg_rdata_q[`BIT_ON_OFF])
		else $error("gain on bit not one");

	AST_GAIN_MANUAL: assert property (rd_gain |=> !reg_rdata_q[`BIT_AUTO])
		else $error("gain not manual");

	AST_GAIN_RANGE8: assert property ((wr_gain && !pix16_sel) |=>
		gain_error_q == ($past(wval) > `GAIN_MAX_8))
		else $error("gain range at 8 bit wrong");

	AST_GAIN_RANGE16: assert property ((wr_gain && pix16_sel) |=>
		gain_error_q == ($past(wval) > `GAIN_MAX_16))
		else $error("gain range at 16 bit wrong");

	AST_GAIN_READBACK: assert property (wr_gain ##1 rd_gain |=>
		reg_rdata_q[`VAL_MSB:`VAL_LSB] == $past(wval, 2))
		else $error("gain readback mismatch");

	AST_GAIN_WORD: assert property (rd_gain |=>
		reg_rdata_q[`VAL_MSB:`VAL_LSB] == $past(gain_value_q))
		else $error("gain word does not show the stored setting");

	AST_GAIN_KNEE: assert property ((gain_value_q == 12'(`GAIN_KNEE)) [*2] |->
		gain_db_tenths_q == 11'(`DB_AT_KNEE))
		else $error("gain knee point wrong");

	AST_GAIN_ZERO: assert property ((gain_value_q == '0) [*2] |->
		gain_db_tenths_q == '0)
		else $error("gain zero point wrong");

	AST_GAIN_DEFAULT: assert property ($past(srst) |->
		gain_value_q == (pix16_q ? `GAIN_DEF_16 : `GAIN_DEF_8))
		else $error("gain default wrong");

	AST_DEPTH_RELOAD: assert property ((depth_change && !wr_gain) |=>
		gain_value_q == (pix16_q ? `GAIN_DEF_16 : `GAIN_DEF_8) && !gain_error_q)
		else $error("depth change did not reload the gain default");

	// ==========================================================================
	// Out-of-range, reserved and read-only checks
	AST_EXP_ERROR: assert property ((wr_exp && wval == '0) |=>
		exposure_error_q && exposure_value_q == '0)
		else $error("out of range exposure not kept and flagged");

	AST_GAIN_KEEP: assert property ((wr_gain && wval > gain_limit(pix16_sel)) |=>
		gain_error_q && gain_value_q == $past(wval))
		else $error("out of range gain not kept and flagged");

	AST_EXP_FLAG_HOLD: assert property (!wr_exp |=> $stable(exposure_error_q))
		else $error("exposure flag changed without a write");

	AST_GAIN_FLAG_HOLD: assert property ((!wr_gain && !depth_change) |=>
		$stable(gain_error_q))
		else $error("gain flag changed without a write");

	AST_RESET_FLAGS: assert property ($past(srst) |->
		!exposure_error_q && !gain_error_q)
		else $error("error flags not clear after reset");

	AST_RESERVED: assert property (reg_rd |=>
		reg_rdata_q[`RSVD_LO_MSB:`RSVD_LO_LSB] == '0
		&& reg_rdata_q[`RSVD_HI_MSB:`RSVD_HI_LSB] == '0)
		else $error("reserved bits not zero");

	AST_UNMAPPED: assert property ((reg_rd && !rd_any) |=> reg_rdata_q == '0)
		else $error("unmapped read not zero");

	AST_RVALID_UNMAPPED: assert property ((reg_rd && !rd_any) |=> reg_rvalid_q)
		else $error("unmapped read not answered");

	AST_RO_HOLD: assert property ((reg_wr && !wr_exp) |=>
		exposure_value_q == $past(exposure_value_q))
		else $error("exposure changed without its write");

	AST_GAIN_HOLD: assert property ((!wr_gain && !depth_change) |=>
		$stable(gain_value_q))
		else $error("gain changed without its write");

	AST_EXP_WR_MASK: assert property (wr_exp |=>
		exposure_value_q == $past(reg_wdata[`VAL_MSB:`VAL_LSB]))
		else $error("exposure did not store the setting field");

	AST_GAIN_WR_MASK: assert property (wr_gain |=>
		gain_value_q == $past(reg_wdata[`VAL_MSB:`VAL_LSB]))
		else $error("gain did not store the setting field");

	// ==========================================================================
	// Coverage
	COV_EXP_BAD: cover property (wr_exp && wval == '0);
	COV_GAIN16: cover property (pix16_sel && wr_gain ##1 rd_gain);
	COV_DEPTH: cover property (depth_change ##1 rd_gain);
	COV_DONE: cover property (exposure_start ##[1:4] exposure_done_q);
	COV_EXP_LONG: cover property (exposure_done_q && expose_set_q > `EXP_MIN);
endmodule : exposure_gain_feature_regs

// ---- logic/feature_params.svh ----
`ifndef FEATURE_PARAMS_SVH
`define FEATURE_PARAMS_SVH

// ==========================================================================
// Register map
`define REG_EXPOSURE 12'h81C
`define REG_GAIN 12'h820

// ==========================================================================
// Field positions, bit 0 of the map is the word's most significant bit
`define BIT_PRESENT 31
`define BIT_ABS 30
`define BIT_ONE_PUSH 26
`define BIT_ON_OFF 25
`define BIT_AUTO 24
`define VAL_MSB 11
`define VAL_LSB 0
`define RSVD_LO_MSB 23
`define RSVD_LO_LSB 12
`define RSVD_HI_MSB 29
`define RSVD_HI_LSB 27

// ==========================================================================
// Setting limits and reset values
`define EXP_MIN 12'h001
`define EXP_RESET 12'h0C8
`define GAIN_MAX_8 12'h2E4
`define GAIN_MAX_16 12'h07D
`define GAIN_DEF_8 12'h096
`define GAIN_DEF_16 12'h000

// ==========================================================================
// Timing
`define STEP_NS 20000
`define CLK_PERIOD_NS 10
`define STEP_CYCLES (`STEP_NS / `CLK_PERIOD_NS)
`define STEP_US 20

// ==========================================================================
// Gain curve, in tenths of a decibel
`define GAIN_KNEE 125
`define GAIN_TOP 740
`define DB_AT_KNEE 82
`define DB_AT_TOP 202

`endif

// ---- logic/feature_pkg.sv ----
package feature_pkg;
	typedef logic [11:0] value_t;
	typedef logic [11:0] offset_t;
	typedef logic [31:0] word_t;
	typedef logic [16:0] micros_t;
	typedef logic [10:0] tenths_t;
	typedef enum logic [0:0] {
		EXP_IDLE = 1'b0,
		EXP_RUN = 1'b1
	} exp_state_e;
endpackage : feature_pkg

// ---- logic/exposure_timer.sv ----
`include "feature_params.svh"
module exposure_timer (
	input wire logic clock,
	input wire logic srst,
	input wire logic start,
	input wire feature_pkg::value_t value,
	output logic exposing_q,
	output logic done_q,
	output feature_pkg::micros_t duration_us_q
);
	import feature_pkg::*;

	exp_state_e state_q;
	logic [10:0] step_q;
	value_t left_q;
	logic step_end;

	assign step_end = (step_q == 11'(`STEP_CYCLES - 1));

	// ==========================================================================
	// Exposure sequencing
	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= EXP_IDLE;
			step_q <= '0;
			left_q <= '0;
			exposing_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			unique case (state_q)
				EXP_IDLE: begin
					step_q <= '0;
					left_q <= value;
					// A zero setting is out of range but still honoured: no exposure at all.
					if (start && value != '0) begin
						state_q <= EXP_RUN;
						exposing_q <= 1'b1;
					end else if (start) begin
						done_q <= 1'b1;
					end
				end
				EXP_RUN: begin
					step_q <= step_end ? '0 : step_q + 11'h001;
					if (step_end) begin
						left_q <= left_q - 12'h001;
						if (left_q == 12'h001) begin
							state_q <= EXP_IDLE;
							exposing_q <= 1'b0;
							done_q <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			duration_us_q <= '0;
		end else if (start && state_q == EXP_IDLE) begin
			duration_us_q <= micros_t'(value) * micros_t'(`STEP_US);
		end
	end

	AST_EXP_STEP: assert property (@(posedge clock) disable iff (srst)
		(state_q == EXP_RUN && step_end && left_q == 12'h001) |=> done_q && !exposing_q)
		else $error("exposure did not end after its last step");
endmodule : exposure_timer

// ---- logic/gain_mapper.sv ----
`include "feature_params.svh"
module gain_mapper (
	input wire logic clock,
	input wire logic srst,
	input wire feature_pkg::value_t value,
	output feature_pkg::tenths_t db_tenths_q
);
	import feature_pkg::*;

	// Two straight segments through the three calibration points.
	function automatic tenths_t to_tenths(input value_t v);
		int unsigned x;
		x = int'(v);
		if (x <= `GAIN_KNEE) begin
			return tenths_t'(x * `DB_AT_KNEE / `GAIN_KNEE);
		end
		return tenths_t'(`DB_AT_KNEE + (x - `GAIN_KNEE) * (`DB_AT_TOP - `DB_AT_KNEE)
			/ (`GAIN_TOP - `GAIN_KNEE));
	endfunction : to_tenths

	always_ff @(posedge clock) begin
		if (srst) begin
			db_tenths_q <= '0;
		end else begin
			db_tenths_q <= to_tenths(value);
		end
	end

	AST_GAIN_CURVE: assert property (@(posedge clock) disable iff (srst)
		(value == 12'(`GAIN_TOP)) |=> db_tenths_q == 11'(`DB_AT_TOP))
		else $error("gain curve wrong at top point");
endmodule : gain_mapper

// ---- bench/exposure_gain_feature_regs_test.sv ----
module exposure_gain_feature_regs_test import feature_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Stimulus and design
	logic clock;
	logic srst;
	offset_t reg_addr;
	logic reg_wr;
	logic reg_rd;
	word_t reg_wdata;
	word_t reg_rdata_q;
	logic reg_rvalid_q;
	logic pix16_sel;
	logic exposure_start;
	value_t exposure_value_q;
	value_t gain_value_q;
	logic exposure_error_q;
	logic gain_error_q;
	logic exposing_q;
	logic exposure_done_q;
	micros_t exposure_us_q;
	tenths_t gain_db_tenths_q;
	int n_fail = 0;
	int checks_done = 0;
	word_t got;

	typedef struct packed {
		offset_t addr;
		word_t wdata;
		word_t rword;
		logic eerr;
		logic gerr;
		logic dbchk;
		tenths_t db;
	} row_s;

	// Rows follow each other, so an error flag set by one row stays until a later row writes the same register.
	localparam row_s ROWS [9] = '{
		'{12'h81C, 32'hFFFF_F001, 32'h8200_0001, 1'h0, 1'h0, 1'h0, 11'h000},
		'{12'h81C, 32'h0000_0FFF, 32'h8200_0FFF, 1'h0, 1'h0, 1'h0, 11'h000},
		'{12'h81C, 32'h0000_0000, 32'h8200_0000, 1'h1, 1'h0, 1'h0, 11'h000},
		'{12'h820, 32'h0000_0000, 32'h8200_0000, 1'h1, 1'h0, 1'h1, 11'h000},
		'{12'h820, 32'h0000_007D, 32'h8200_007D, 1'h1, 1'h0, 1'h1, 11'h052},
		'{12'h820, 32'hFFFF_F2E4, 32'h8200_02E4, 1'h1, 1'h0, 1'h1, 11'h0CA},
		'{12'h820, 32'h0000_02E5, 32'h8200_02E5, 1'h1, 1'h1, 1'h0, 11'h000},
		'{12'h81C, 32'h0000_00C8, 32'h8200_00C8, 1'h0, 1'h1, 1'h0, 11'h000},
		'{12'h824, 32'h0000_0123, 32'h0000_0000, 1'h0, 1'h1, 1'h0, 11'h000}
	};

	exposure_gain_feature_regs dut_u (
		.clock(clock),
		.srst(srst),
		.reg_addr(reg_addr),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_wdata(reg_wdata),
		.reg_rdata_q(reg_rdata_q),
		.reg_rvalid_q(reg_rvalid_q),
		.pix16_sel(pix16_sel),
		.exposure_start(exposure_start),
		.exposure_value_q(exposure_value_q),
		.gain_value_q(gain_value_q),
		.exposure_error_q(exposure_error_q),
		.gain_error_q(gain_error_q),
		.exposing_q(exposing_q),
		.exposure_done_q(exposure_done_q),
		.exposure_us_q(exposure_us_q),
		.gain_db_tenths_q(gain_db_tenths_q)
	);

	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
			n_fail++;
		end
	endtask : chk

	task automatic write_reg(input offset_t a, input word_t d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clock);
		reg_wr = 1'h0;
	endtask : write_reg

	task automatic read_reg(input offset_t a, output word_t d);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge clock);
		reg_rd = 1'h0;
		chk("rvalid", 32'h1, {31'h0, reg_rvalid_q});
		d = reg_rdata_q;
	endtask : read_reg

	// The second start and its lack of effect on the length are part of every run with a nonzero setting.
	task automatic run_exp(input value_t v);
		int n;
		write_reg(12'h81C, {20'h0, v});
		@(negedge clock);
		exposure_start = 1'h1;
		@(negedge clock);
		exposure_start = 1'h0;
		chk("exposing", {31'h0, v != 12'h000}, {31'h0, exposing_q});
		chk("exposure_us", 32'(v) * 32'h14, {15'h0, exposure_us_q});
		n = 0;
		while (exposure_done_q !== 1'h1 && n < 20000) begin
			exposure_start = (n == 100);
			@(negedge clock);
			n++;
		end
		exposure_start = 1'h0;
		chk("exposure_cycles", 32'(v) * 32'h7D0, 32'(n));
		chk("exposing_end", 32'h0, {31'h0, exposing_q});
	endtask : run_exp

	task automatic give_verdict();
		$display("checks_done %0d n_fail %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// Main sequence
	initial begin
		srst = 1'h1;
		reg_addr = 12'h000;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_wdata = 32'h0;
		pix16_sel = 1'h0;
		exposure_start = 1'h0;
		repeat (12) @(negedge clock);
		srst = 1'h0;
		read_reg(12'h81C, got);
		chk("exposure_reset", 32'h8200_00C8, got);
		read_reg(12'h820, got);
		chk("gain_reset", 32'h8200_0096, got);
		chk("errors_reset", 32'h0, {exposure_error_q, gain_error_q});
		$display("test reset done");
		foreach (ROWS[i]) begin
			write_reg(ROWS[i].addr, ROWS[i].wdata);
			read_reg(ROWS[i].addr, got);
			chk("row_rdata", ROWS[i].rword, got);
			chk("row_exposure_error", {31'h0, ROWS[i].eerr}, {31'h0, exposure_error_q});
			chk("row_gain_error", {31'h0, ROWS[i].gerr}, {31'h0, gain_error_q});
			if (ROWS[i].dbchk)
				chk("row_gain_db", {21'h0, ROWS[i].db}, {21'h0, gain_db_tenths_q});
		end
		$display("test rows done");
		@(negedge clock);
		pix16_sel = 1'h1;
		repeat (2) @(negedge clock);
		read_reg(12'h820, got);
		chk("gain_default_16", 32'h8200_0000, got);
		write_reg(12'h820, 32'h0000_007D);
		chk("gain_error_125", 32'h0, {31'h0, gain_error_q});
		write_reg(12'h820, 32'h0000_007E);
		chk("gain_error_126", 32'h1, {31'h0, gain_error_q});
		chk("gain_kept_126", 32'h7E, {20'h0, gain_value_q});
		pix16_sel = 1'h0;
		repeat (2) @(negedge clock);
		read_reg(12'h820, got);
		chk("gain_default_8", 32'h8200_0096, got);
		$display("test depth done");
		run_exp(12'h001);
		run_exp(12'h002);
		run_exp(12'h000);
		$display("test exposure done");
		srst = 1'h1;
		pix16_sel = 1'h1;
		@(negedge clock);
		srst = 1'h0;
		read_reg(12'h820, got);
		chk("gain_reset_16", 32'h8200_0000, got);
		chk("exposure_rereset", 32'h0C8, {20'h0, exposure_value_q});
		chk("errors_rereset", 32'h0, {exposure_error_q, gain_error_q});
		$display("test rereset done");
		give_verdict();
	end

	// Three exposures take about six thousand cycles, so this leaves ample margin.
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule : exposure_gain_feature_regs_test
